// file: rtl/aif_pkg.sv
// Purpose: Shared constants for the interrupt, format and sample queue block
// Assumes: 8-bit register port, byte offsets as printed
// Notes: Field positions follow the common interrupt bit layout
package aif_pkg;
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h2E;
  localparam logic [7:0] ADDR_INT_MAP = 8'h2F;
  localparam logic [7:0] ADDR_INT_FLAGS = 8'h30;
  localparam logic [7:0] ADDR_FORMAT = 8'h31;
  localparam logic [7:0] ADDR_X_LOW = 8'h32;
  localparam logic [7:0] ADDR_X_HIGH = 8'h33;
  localparam logic [7:0] ADDR_Y_LOW = 8'h34;
  localparam logic [7:0] ADDR_Y_HIGH = 8'h35;
  localparam logic [7:0] ADDR_Z_LOW = 8'h36;
  localparam logic [7:0] ADDR_Z_HIGH = 8'h37;
  localparam logic [7:0] ADDR_QUEUE_CTL = 8'h38;
  localparam logic [7:0] ADDR_QUEUE_STAT = 8'h39;
  // Interrupt bit positions
  localparam int BIT_READY = 7;
  localparam int BIT_ACT = 4;
  localparam int BIT_INACT = 3;
  localparam int BIT_WMARK = 1;
  localparam int BIT_OVRUN = 0;
  localparam logic [7:0] INT_USED_MASK = 8'h9B;
  // Format register fields
  localparam int FMT_SELF_TEST = 7;
  localparam int FMT_THREE_WIRE = 6;
  localparam int FMT_INVERT = 5;
  localparam int FMT_SCALED = 3;
  localparam int FMT_LEFT = 2;
  localparam logic [7:0] FMT_USED_MASK = 8'hEF;
  // Queue control fields
  localparam int QC_TRIG_PIN = 5;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam int QUEUE_DEPTH = 32;
  typedef enum logic [1:0] {
    QM_BYPASS = 2'h0,
    QM_FILL = 2'h1,
    QM_STREAM = 2'h2,
    QM_TRIGGER = 2'h3
  } aif_mode_type;
endpackage

// file: rtl/aif_regs.sv
// Purpose: Interrupt, output format, axis data and sample queue registers
// Assumes: Samples arrive as signed 13-bit values at the 2.9 mg/LSB scale
// Notes: Activity and inactivity events come from the detection engines
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module aif_regs
  import aif_pkg::*;
#(
  parameter int DEPTH = QUEUE_DEPTH
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic sample_valid_i,
  input wire logic [12:0] sample_x_i,
  input wire logic [12:0] sample_y_i,
  input wire logic [12:0] sample_z_i,
  input wire logic activity_i,
  input wire logic inactivity_i,
  output logic first_interrupt_pin_o,
  output logic second_interrupt_pin_o,
  output logic self_test_o,
  output logic three_wire_o
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int AW = $clog2(DEPTH);

  //////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] enable_r, map_r, format_r, qctl_r;
  logic act_flag_r, inact_flag_r, ovrun_r, trig_seen_r;
  logic [38:0] mem_r [DEPTH];
  logic [AW-1:0] rd_ptr_r, wr_ptr_r;
  logic [CW-1:0] count_r;
  logic [38:0] out_r;
  logic out_valid_r;
  logic [7:0] rdata_r;
  logic pin1_r, pin2_r, st_r, tw_r;

  aif_mode_type mode;
  assign mode = aif_mode_type'(qctl_r[7:6]);

  logic wr_hit, rd_axis, rd_flags;
  assign rd_axis = rd_i && addr_i >= ADDR_X_LOW && addr_i <= ADDR_Z_HIGH;
  assign rd_flags = rd_i && addr_i == ADDR_INT_FLAGS;
  assign wr_hit = wr_i;

  // Writable control registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      enable_r <= RESET_VALUE;
      map_r <= RESET_VALUE;
      format_r <= RESET_VALUE;
      qctl_r <= RESET_VALUE;
    end else if (wr_hit) begin
      unique case (addr_i)
        ADDR_INT_ENABLE: enable_r <= wdata_i & INT_USED_MASK;
        ADDR_INT_MAP: map_r <= wdata_i & INT_USED_MASK;
        ADDR_FORMAT: format_r <= wdata_i & FMT_USED_MASK;
        ADDR_QUEUE_CTL: qctl_r <= wdata_i;
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sample formatting: clip, scale and justify one axis into 16 bits
  function automatic logic [15:0] fmt_axis(input logic [12:0] s,
                                           input logic [7:0] f);
    logic [1:0] rng;
    logic [3:0] bits;
    logic signed [12:0] v;
    logic signed [12:0] lim;
    logic [15:0] res;
    rng = f[1:0];
    v = $signed(s);
    // Full scale width: 10 bits fixed, or 10..13 with fixed scale
    bits = f[FMT_SCALED] ? 4'(10 + rng) : 4'hA;
    lim = 13'sh1FF <<< rng; // Range limit at full scale
    if (rng != 2'h3) begin
      if (v > lim) v = lim;
      if (v < -lim - 13'sh1) v = -lim - 13'sh1;
    end
    if (!f[FMT_SCALED]) v = v >>> rng; // Range-dependent scale
    res = 16'($signed(v)); // Right justified, sign extended
    if (f[FMT_LEFT]) res = res << (5'd16 - 5'(bits));
    return res;
  endfunction

  logic [38:0] new_word;
  assign new_word = {sample_z_i, sample_y_i, sample_x_i};

  //////////////////////////////////////////////////////////////////////////
  // Sample queue
  logic push, pop, full, drop_old, can_take, trig_src, wm_hit;
  logic ints_routed1, ints_routed2, refill_direct;
  assign full = count_r == CW'(DEPTH);
  assign trig_src = qctl_r[QC_TRIG_PIN] ? ints_routed2 : ints_routed1;
  // Trigger mode before trigger behaves as stream holding samples-field count
  always_comb begin
    can_take = 1'b0;
    drop_old = 1'b0;
    unique case (mode)
      QM_BYPASS: can_take = 1'b0;
      QM_FILL: can_take = !full;
      QM_STREAM: begin
        can_take = 1'b1;
        drop_old = full;
      end
      QM_TRIGGER: begin
        can_take = trig_seen_r ? !full : 1'b1;
        drop_old = !trig_seen_r && (count_r >= CW'(qctl_r[4:0]));
      end
    endcase
  end
  // A read that empties the stage while a sample arrives takes it directly,
  // so the stage never sits empty with entries still queued behind it
  assign refill_direct = sample_valid_i && can_take &&
    (!out_valid_r || (pop && count_r == '0));
  assign push = sample_valid_i && can_take && out_valid_r &&
    !(pop && count_r == '0);
  // Each axis read outside bypass pops one level; output stage is the 33rd entry
  assign pop = rd_axis && out_valid_r && mode != QM_BYPASS;

  logic [38:0] head;
  assign head = mem_r[rd_ptr_r];

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rd_ptr_r <= '0;
      wr_ptr_r <= '0;
      count_r <= '0;
      out_r <= '0;
      out_valid_r <= 1'b0;
    end else if (mode == QM_BYPASS) begin
      rd_ptr_r <= '0;
      wr_ptr_r <= '0;
      count_r <= '0;
      if (sample_valid_i) out_r <= new_word; // Latest sample only
      if (sample_valid_i) out_valid_r <= 1'b1;
      else if (rd_axis) out_valid_r <= 1'b0;
    end else begin
      logic take_head, do_push, do_drop;
      take_head = pop && count_r != '0;
      do_push = push && !(drop_old && !take_head);
      do_drop = push && drop_old && !take_head;
      // Output stage: fill from head, or directly when both empty
      if (refill_direct) begin
        out_r <= new_word;
        out_valid_r <= 1'b1;
      end else if (pop) begin
        out_r <= head;
        out_valid_r <= count_r != '0;
      end
      if (push) begin
        mem_r[wr_ptr_r] <= new_word;
        wr_ptr_r <= AW'((32'(wr_ptr_r) + 1) % DEPTH);
      end
      if (take_head || do_drop) // Oldest advances
        rd_ptr_r <= AW'((32'(rd_ptr_r) + 1) % DEPTH);
      if (do_push && !take_head) count_r <= count_r + CW'(1);
      else if (!push && take_head) count_r <= count_r - CW'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Flags: hardware set wins over clear
  assign wm_hit = (qctl_r[4:0] == 5'h0) ||
    (mode != QM_BYPASS && mode != QM_TRIGGER &&
     count_r >= CW'(qctl_r[4:0]));
  logic ready_flag;
  assign ready_flag = out_valid_r; // Clears as data is read
  logic [7:0] flags;
  assign flags = {ready_flag, 2'b00, act_flag_r, inact_flag_r, 1'b0,
                  wm_hit, ovrun_r};

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      act_flag_r <= 1'b0;
      inact_flag_r <= 1'b0;
      ovrun_r <= 1'b0;
    end else begin
      // Flag register read clears activity pair
      act_flag_r <= activity_i | (act_flag_r & ~rd_flags);
      inact_flag_r <= inactivity_i | (inact_flag_r & ~rd_flags);
      // Overrun: sample lost, independent of enable
      ovrun_r <= (sample_valid_i && out_valid_r && (!can_take ||
        mode == QM_BYPASS)) | (ovrun_r & ~rd_axis);
    end
  end

  // Trigger capture
  logic [7:0] active;
  assign active = flags & enable_r;
  assign ints_routed1 = |(active & ~map_r);
  assign ints_routed2 = |(active & map_r);
  always_ff @(posedge clk_i) begin
    if (reset_i) trig_seen_r <= 1'b0;
    else if (mode != QM_TRIGGER) trig_seen_r <= 1'b0;
    else if (trig_src) trig_seen_r <= 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////
  // Pins, registered with polarity
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pin1_r <= 1'b0;
      pin2_r <= 1'b0;
      st_r <= 1'b0;
      tw_r <= 1'b0;
    end else begin
      pin1_r <= ints_routed1 ^ format_r[FMT_INVERT];
      pin2_r <= ints_routed2 ^ format_r[FMT_INVERT];
      st_r <= format_r[FMT_SELF_TEST];
      tw_r <= format_r[FMT_THREE_WIRE];
    end
  end
  assign first_interrupt_pin_o = pin1_r;
  assign second_interrupt_pin_o = pin2_r;
  assign self_test_o = st_r;
  assign three_wire_o = tw_r;

  //////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  logic [15:0] fx, fy, fz;
  assign fx = fmt_axis(out_r[12:0], format_r);
  assign fy = fmt_axis(out_r[25:13], format_r);
  assign fz = fmt_axis(out_r[38:26], format_r);
  always_ff @(posedge clk_i) begin
    if (reset_i) rdata_r <= RESET_VALUE;
    else if (rd_i) begin
      unique case (addr_i)
        ADDR_INT_ENABLE: rdata_r <= enable_r;
        ADDR_INT_MAP: rdata_r <= map_r;
        ADDR_INT_FLAGS: rdata_r <= flags;
        ADDR_FORMAT: rdata_r <= format_r;
        ADDR_X_LOW: rdata_r <= fx[7:0];
        ADDR_X_HIGH: rdata_r <= fx[15:8];
        ADDR_Y_LOW: rdata_r <= fy[7:0];
        ADDR_Y_HIGH: rdata_r <= fy[15:8];
        ADDR_Z_LOW: rdata_r <= fz[7:0];
        ADDR_Z_HIGH: rdata_r <= fz[15:8];
        ADDR_QUEUE_CTL: rdata_r <= qctl_r;
        ADDR_QUEUE_STAT: rdata_r <= {trig_seen_r, 1'b0,
          6'(count_r)};
        default: rdata_r <= RESET_VALUE;
      endcase
    end else rdata_r <= RESET_VALUE;
  end
  assign rdata_o = rdata_r;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  property p_flag_clear;
    @(posedge clk_i) disable iff (reset_i)
      rd_flags && !activity_i |=> !act_flag_r;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("activity flag not cleared by flag read");

  property p_gate;
    @(posedge clk_i) disable iff (reset_i)
      enable_r == 8'h00 && !format_r[FMT_INVERT] ##1
      !format_r[FMT_INVERT] |-> !pin1_r && !pin2_r;
  endproperty
  a_gate: assert property (p_gate)
    else $error("interrupt pin active with all enables off");

  property p_count_max;
    @(posedge clk_i) disable iff (reset_i) count_r <= CW'(DEPTH);
  endproperty
  a_count_max: assert property (p_count_max)
    else $error("queue count above depth");

  property p_fill_stop;
    @(posedge clk_i) disable iff (reset_i)
      mode == QM_FILL && full && !pop && !wr_hit |=> full;
  endproperty
  a_fill_stop: assert property (p_fill_stop)
    else $error("fill mode left full without a read");

  property p_wm_zero;
    @(posedge clk_i) disable iff (reset_i)
      rd_flags && qctl_r[4:0] == 5'h0 |=> rdata_o[BIT_WMARK];
  endproperty
  a_wm_zero: assert property (p_wm_zero)
    else $error("zero samples field did not set watermark");

  property p_polarity;
    @(posedge clk_i) disable iff (reset_i)
      ##1 $stable(format_r) |-> pin1_r == ($past(ints_routed1) ^
      format_r[FMT_INVERT]);
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("first pin polarity wrong");

  property p_trig_hold;
    @(posedge clk_i) disable iff (reset_i)
      trig_seen_r && mode == QM_TRIGGER && !wr_hit |=> trig_seen_r;
  endproperty
  a_trig_hold: assert property (p_trig_hold)
    else $error("trigger seen dropped in trigger mode");

  property p_bypass_empty;
    @(posedge clk_i) disable iff (reset_i)
      mode == QM_BYPASS ##1 mode == QM_BYPASS |-> count_r == '0;
  endproperty
  a_bypass_empty: assert property (p_bypass_empty)
    else $error("queue holds entries in bypass");
endmodule

// file: verification/aif_host.sv
// Purpose: Host model that reaches the registers over the plain port
// Assumes: One-cycle strobes, read data stands in the cycle after the strobe
// Notes: Released address and data lines show the inverse of the last value
`timescale 1ns/1ps
module aif_host (
  input wire logic clk_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [7:0] rdata_i
);
  // Bus idle at time zero
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // Single write cycle; callers set up functions before enables
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  // Single read; a queue level is taken as one byte per pass
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask
endmodule

// file: verification/accel_irq_format_fifo_regs_test.sv
// Purpose: Self-checking bench for the interrupt, format and queue block
// Assumes: Samples and detection pulses share the block clock
// Notes: Expected bytes come from a queue model kept in the bench
`timescale 1ns/1ps
module accel_irq_format_fifo_regs_test;
  import aif_pkg::*;
  logic clk_i;
  logic reset_i;
  logic [7:0] addr, wdata, rdata, got;
  logic wr, rd, sv, act, inact, pin1, pin2, st, tw;
  logic [12:0] sx, sy, sz;
  int mismatches, total_checks, cycles, seed, k;
  int q[$];
  logic [7:0] rst_addr [6] = '{8'h2E, 8'h2F, 8'h30, 8'h31, 8'h38, 8'h39};
  logic [7:0] rst_val [6] = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00};
  ////////////////////////////////////////////////////////////////////////
  // Design, host model and clock
  aif_regs #(.DEPTH(QUEUE_DEPTH)) u_dut (.clk_i(clk_i), .reset_i(reset_i),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .sample_valid_i(sv), .sample_x_i(sx), .sample_y_i(sy), .sample_z_i(sz),
    .activity_i(act), .inactivity_i(inact), .first_interrupt_pin_o(pin1),
    .second_interrupt_pin_o(pin2), .self_test_o(st), .three_wire_o(tw));
  aif_host u_host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd), .rdata_i(rdata));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks = total_checks + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, got);
    chk(got, e);
  endtask
  // One sample pulse with the given x value, then idle cycles
  task automatic push(input logic [12:0] x);
    @(posedge clk_i);
    sv <= 1'b1;
    sx <= x;
    sy <= ~x;
    sz <= x ^ 13'h0055;
    @(posedge clk_i);
    sv <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic pulse_act();
    @(posedge clk_i);
    act <= 1'b1;
    inact <= 1'b1;
    @(posedge clk_i);
    act <= 1'b0;
    inact <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic pins(input logic e1, input logic e2);
    chk({7'h00, pin1}, {7'h00, e1});
    chk({7'h00, pin2}, {7'h00, e2});
  endtask
  task automatic fill40(input logic [7:0] ctl);
    u_host.wr(ADDR_QUEUE_CTL, ctl);
    q.delete();
    for (k = 0; k < 40; k++) begin
      q.push_back($random(seed) & 32'h1FF);
      push(q[k][12:0]);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset_i = 1'b1;
    {sv, act, inact} = 3'h0;
    {sx, sy, sz} = 39'h0;
    {mismatches, total_checks, cycles} = 0;
    seed = 32'h548f;
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    // Reset values, unmapped and read-only places
    // Zero samples field already shows the watermark after reset
    for (k = 0; k < 6; k++)
      rchk(rst_addr[k], rst_val[k]);
    rchk(8'h50, 8'h00);
    u_host.wr(ADDR_QUEUE_STAT, 8'h1F);
    rchk(ADDR_QUEUE_STAT, 8'h00);
    $display("test reset done");
    // Read/write places and format outputs
    u_host.wr(ADDR_INT_ENABLE, 8'h9B);
    rchk(ADDR_INT_ENABLE, 8'h9B);
    u_host.wr(ADDR_FORMAT, 8'hC3);
    rchk(ADDR_FORMAT, 8'hC3);
    chk({6'h00, st, tw}, 8'h03);
    u_host.wr(ADDR_INT_ENABLE, 8'h00);
    $display("test format done");
    // Bypass: clipping, resolution, routing, masking, polarity
    u_host.wr(ADDR_FORMAT, 8'h08);
    push(13'h0300);
    rchk(ADDR_X_LOW, 8'hFF);
    u_host.wr(ADDR_FORMAT, 8'h03);
    push(13'h0100);
    rchk(ADDR_X_LOW, 8'h20);
    u_host.wr(ADDR_FORMAT, 8'h0B);
    u_host.wr(ADDR_INT_ENABLE, 8'h80);
    push(13'h0123);
    pins(1'b1, 1'b0);
    rchk(ADDR_INT_FLAGS, 8'h82);
    rchk(ADDR_X_LOW, 8'h23);
    rchk(ADDR_INT_FLAGS, 8'h02);
    u_host.wr(ADDR_INT_MAP, 8'h80);
    push(13'h0045);
    pins(1'b0, 1'b1);
    u_host.wr(ADDR_INT_ENABLE, 8'h00);
    repeat (2) @(posedge clk_i);
    pins(1'b0, 1'b0);
    rchk(ADDR_INT_FLAGS, 8'h82);
    u_host.wr(ADDR_FORMAT, 8'h2B);
    repeat (2) @(posedge clk_i);
    pins(1'b1, 1'b1);
    u_host.wr(ADDR_FORMAT, 8'h0B);
    rchk(ADDR_X_LOW, 8'h45);
    // Left justified 10-bit, then a negative sample sign extended
    u_host.wr(ADDR_FORMAT, 8'h04);
    rchk(ADDR_X_HIGH, 8'h11);
    u_host.wr(ADDR_FORMAT, 8'h0B);
    push(13'h1F00);
    rchk(ADDR_X_HIGH, 8'hFF);
    rchk(ADDR_X_LOW, 8'h00);
    $display("test bypass done");
    // Activity flag cleared by reading the flags
    u_host.wr(ADDR_INT_MAP, 8'h00);
    u_host.wr(ADDR_INT_ENABLE, 8'h10);
    pulse_act();
    pins(1'b1, 1'b0);
    rchk(ADDR_INT_FLAGS, 8'h1A);
    rchk(ADDR_INT_FLAGS, 8'h02);
    repeat (2) @(posedge clk_i);
    pins(1'b0, 1'b0);
    u_host.wr(ADDR_INT_ENABLE, 8'h00);
    $display("test activity done");
    // Fill-once: stops at 32 stored plus the output stage
    fill40(8'h44);
    rchk(ADDR_QUEUE_STAT, 8'h20);
    rchk(ADDR_INT_FLAGS, 8'h83);
    for (k = 0; k < 33; k++)
      rchk(ADDR_X_LOW, q[k][7:0]);
    rchk(ADDR_QUEUE_STAT, 8'h00);
    rchk(ADDR_INT_FLAGS, 8'h00);
    $display("test fill done");
    // Stream: newest sample comes out last
    fill40(8'h84);
    rchk(ADDR_QUEUE_STAT, 8'h20);
    for (k = 0; k < 33; k++)
      u_host.rd(ADDR_X_LOW, got);
    chk(got, q[39][7:0]);
    $display("test stream done");
    // Samples field of zero raises the watermark at once
    u_host.wr(ADDR_QUEUE_CTL, 8'h40);
    u_host.rd(ADDR_INT_FLAGS, got);
    chk(got & 8'h02, 8'h02);
    // Trigger from the first pin's interrupt
    u_host.wr(ADDR_QUEUE_CTL, 8'hC2);
    rchk(ADDR_QUEUE_STAT, 8'h00);
    u_host.wr(ADDR_INT_ENABLE, 8'h10);
    pulse_act();
    u_host.rd(ADDR_QUEUE_STAT, got);
    chk(got & 8'h80, 8'h80);
    $display("test trigger done");
    give_verdict();
  end
endmodule
